// file: hw/freq_ref_pkg.sv
// constants shared by the frequency reference selector
// assumes a 125 MHz aclk; frequencies are in 0.01 Hz units, limits in 0.1 percent
package freq_ref_pkg;
	localparam int          FW              = 16;            // frequency word, 0.01 Hz per lsb
	localparam int          PW              = 11;            // percent word, 0.1 percent per lsb
	localparam int          NUM_IN          = 8;             // multi-function digital inputs
	localparam int          NUM_PRESET      = 16;
	// register byte offsets
	localparam logic [7:0]  ADDR_PRESET0    = 8'h00;         // 16 words up to 0x3C
	localparam logic [7:0]  ADDR_JOG        = 8'h40;
	localparam logic [7:0]  ADDR_UPPER      = 8'h44;
	localparam logic [7:0]  ADDR_LOWER      = 8'h48;
	localparam logic [7:0]  ADDR_JUMP1      = 8'h4C;
	localparam logic [7:0]  ADDR_JUMP2      = 8'h50;
	localparam logic [7:0]  ADDR_JWIDTH     = 8'h54;
	localparam logic [7:0]  ADDR_HOLD       = 8'h58;
	localparam logic [7:0]  ADDR_BSTEP      = 8'h5C;
	localparam logic [7:0]  ADDR_BRAMP      = 8'h60;
	localparam logic [7:0]  ADDR_SAVED      = 8'h64;
	localparam logic [7:0]  ADDR_MAXF       = 8'h68;
	localparam logic [7:0]  ADDR_ACCEL      = 8'h6C;
	localparam logic [7:0]  ADDR_DECEL      = 8'h70;
	localparam logic [7:0]  ADDR_FCODE_LO   = 8'h74;         // inputs 0..3, one byte each
	localparam logic [7:0]  ADDR_FCODE_HI   = 8'h78;         // inputs 4..7
	localparam logic [7:0]  ADDR_STATUS     = 8'h7C;         // [15:0] ref, [16] alarm, [17] run, [31:18] 0
	localparam int          STAT_ALARM      = 16;
	localparam int          STAT_RUN        = 17;
	// reset values
	localparam logic [NUM_PRESET-1:0][FW-1:0] RST_PRESET = {
		16'h1388, 16'h1388, 16'h1388, 16'h1388, 16'h1194, 16'h1068, 16'h0FA0, 16'h0DAC,
		16'h0BB8, 16'h09C4, 16'h07D0, 16'h05DC, 16'h04B0, 16'h03E8, 16'h0320, 16'h01F4};
	localparam logic [FW-1:0] RST_JOG         = 16'h0258;      // 6.00 Hz
	localparam logic [PW-1:0] RST_UPPER       = 11'h3E8;       // 100.0 percent
	localparam logic [PW-1:0] MAX_UPPER       = 11'h44C;       // 110.0 percent
	localparam logic [PW-1:0] RST_LOWER       = 11'h000;
	localparam logic [FW-1:0] RST_JWIDTH      = 16'h0064;      // 1.00 Hz
	localparam logic [FW-1:0] RST_MAXF        = 16'h1388;      // plain default, 50.00 Hz
	localparam logic [FW-1:0] MAX_BSTEP       = 16'h270F;      // 99.99 Hz
	localparam logic [FW-1:0] RST_RATE        = 16'h0100;      // one less than the cycles per 0.01 Hz step
	localparam logic [1:0]    HOLD_CLEAR      = 2'h0;
	localparam logic [1:0]    HOLD_SAVE       = 2'h1;
	localparam logic [1:0]    HOLD_ACCEPT     = 2'h2;
	// input function codes
	localparam logic [7:0]  FC_STEP1        = 8'h05;
	localparam logic [7:0]  FC_STEP2        = 8'h06;
	localparam logic [7:0]  FC_STEP3        = 8'h07;
	localparam logic [7:0]  FC_STEP4        = 8'h08;
	localparam logic [7:0]  FC_JOG          = 8'h09;
	localparam logic [7:0]  FC_UP           = 8'h0A;
	localparam logic [7:0]  FC_DOWN         = 8'h0B;
	localparam logic [7:0]  FC_UP2          = 8'h0C;
	localparam logic [7:0]  FC_DOWN2        = 8'h0D;
	localparam logic [7:0]  RST_FCODE       = 8'h00;
	// timing
	localparam longint      CLK_HZ          = 125000000;
	localparam longint      BIAS_LONG_MS    = 2000;
	localparam longint      BIAS_LONG_CYC   = BIAS_LONG_MS * CLK_HZ / 1000;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// file: hw/frequency_reference_selector.sv
// frequency reference selector: preset/jog select, up/down, bias, limits, jump bands, ramp
// assumes AXI4-Lite register access and contact inputs already debounced outside
// Contract
// - sixteen presets plus jog, binary step select
// - jog input overrides the step inputs
// - function codes 5-8 steps, 9 jog
// - preset changes ramp at accel/decel times
// - new upper limit rewrites presets above it
// - upper clamp in percent, 0-110, reset 100
// - lower limit raises low references
// - inside band hold at band upper edge
// - zero centre disables band, width 1 Hz
// - never settle in band, cross with first times
// - hold mode active only with up/down codes
// - mode 0 adjusts while running, clears at stop
// - mode 1 saves at stop, pre-run press clears
// - mode 2 adjusts while stopped, saves at stop
// - second pair changes bias, step 0-99.99 Hz
// - zero step ramps bias at bias ramp times
// - nonzero step: long press uses up/down times
// - bias select 0 uses current accel/decel
// - both up/down pairs assigned raises alarm
`timescale 1ns/1ps
module frequency_reference_selector
	import freq_ref_pkg::*;
#(
	parameter longint LONG_PRESS_CYC = BIAS_LONG_CYC
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [NUM_IN-1:0] digital_in,
	input  wire logic              run_cmd,
	output logic      [FW-1:0]     freq_reference,
	output logic                   reference_alarm,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic      [1:0]        s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic      [31:0]       s_axi_rdata,
	output logic      [1:0]        s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	typedef struct packed {
		logic [NUM_PRESET-1:0][FW-1:0] preset;
		logic [FW-1:0]                 jog;
		logic [PW-1:0]                 upper_pct;
		logic [PW-1:0]                 lower_pct;
		logic [1:0][FW-1:0]            jcentre;
		logic [FW-1:0]                 jwidth;
		logic [1:0]                    hold_mode;
		logic [FW-1:0]                 bstep;
		logic                          bramp_sel;
		logic [FW-1:0]                 saved;
		logic [FW-1:0]                 maxf;
		logic [FW-1:0]                 accel;
		logic [FW-1:0]                 decel;
		logic [NUM_IN-1:0][7:0]        fcode;
		logic                          limit_new;
		logic [FW-1:0]                 ud_ref;
		logic [FW-1:0]                 bias;
		logic [FW-1:0]                 btarget;
		logic [31:0]                   press_cnt;
		logic                          press_prev;
		logic                          run_prev;
		logic [FW-1:0]                 target;
		logic [FW-1:0]                 outf;
		logic [FW-1:0]                 tick;
		logic [FW-1:0]                 btick;
		logic [FW-1:0]                 utick;
		logic                          alarm;
		logic                          aw_have;
		logic                          w_have;
		logic [7:0]                    awaddr;
		logic [31:0]                   wdata;
		logic                          awready;
		logic                          wready;
		logic                          bvalid;
		logic [1:0]                    bresp;
		logic                          arready;
		logic                          rvalid;
		logic [31:0]                   rdata;
		logic [1:0]                    rresp;
	} state_type;

	state_type            st_q;
	state_type            st_d;
	logic [NUM_IN:0]      sync_in;
	logic [NUM_IN-1:0]    din;
	logic                 run;
	logic [NUM_IN-1:0][15:0] fn_one;
	logic [15:0]          fn_act;
	logic [15:0]          fn_asg;
	logic [26:0]          upper_prod;
	logic [26:0]          lower_prod;
	logic [FW-1:0]        upper_hz;
	logic [FW-1:0]        lower_hz;
	logic [3:0]           step_idx;
	logic [FW-1:0]        base_ref;
	logic [FW-1:0]        sel_ref;
	logic [FW:0]          biased;
	logic [FW:0]          clamped;
	logic [FW:0]          jumped;
	logic [FW:0]          half;
	logic                 ud1_en;
	logic                 ud2_en;
	logic [1:0]           mode;
	logic                 up2;
	logic                 dn2;
	logic                 long_press;
	logic [FW-1:0]        brate;
	logic [FW-1:0]        orate;

	input_sync #(.WIDTH(NUM_IN + 1)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.raw     ({run_cmd, digital_in}),
		.synced  (sync_in)
	);
	assign din = sync_in[NUM_IN-1:0];
	assign run = sync_in[NUM_IN];

	// per-input decode of its function code into a one-hot of codes below 16
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IN; gi++) begin : g_fn
			assign fn_one[gi] = (st_q.fcode[gi] < 8'h10) ? (16'h0001 << st_q.fcode[gi][3:0]) : 16'h0000;
		end
	endgenerate

	// which functions are assigned, and which are asserted now
	always_comb begin
		fn_act = 16'h0000;
		fn_asg = 16'h0000;
		for (int i = 0; i < NUM_IN; i++) begin
			fn_asg = fn_asg | fn_one[i];
			fn_act = fn_act | (din[i] ? fn_one[i] : 16'h0000);
		end
	end

	// limits in 0.01 Hz from percent of maximum output frequency
	assign upper_prod = st_q.maxf * st_q.upper_pct;
	assign lower_prod = st_q.maxf * st_q.lower_pct;
	assign upper_hz   = 16'(upper_prod / 27'd1000);
	assign lower_hz   = 16'(lower_prod / 27'd1000);

	assign ud1_en     = fn_asg[FC_UP[3:0]] | fn_asg[FC_DOWN[3:0]];
	assign ud2_en     = fn_asg[FC_UP2[3:0]] | fn_asg[FC_DOWN2[3:0]];
	assign mode       = (ud1_en | ud2_en) ? st_q.hold_mode : HOLD_CLEAR;
	assign up2        = fn_act[FC_UP2[3:0]];
	assign dn2        = fn_act[FC_DOWN2[3:0]];
	assign long_press = st_q.press_cnt >= 32'(LONG_PRESS_CYC);

	// reference path: select, bias, clamp, jump
	always_comb begin
		step_idx = {fn_act[FC_STEP4[3:0]], fn_act[FC_STEP3[3:0]], fn_act[FC_STEP2[3:0]], fn_act[FC_STEP1[3:0]]};
		base_ref = fn_act[FC_JOG[3:0]] ? st_q.jog : st_q.preset[step_idx];
		sel_ref  = ud1_en ? st_q.ud_ref : base_ref;
		biased   = {1'b0, sel_ref} + {1'b0, st_q.bias};
		clamped  = (biased > {1'b0, upper_hz}) ? {1'b0, upper_hz} : biased;
		if (clamped < {1'b0, lower_hz}) begin
			clamped = {1'b0, lower_hz};
		end
		half   = {2'b00, st_q.jwidth[FW-1:1]};
		jumped = clamped;
		// centres ascend, so the first band is examined first
		for (int j = 0; j < 2; j++) begin
			if (st_q.jcentre[j] != 16'h0000 &&
			    jumped + half >= {1'b0, st_q.jcentre[j]} && jumped < {1'b0, st_q.jcentre[j]} + half) begin
				jumped = {1'b0, st_q.jcentre[j]} + half;
			end
		end
		if (jumped[FW]) begin
			jumped = {1'b0, 16'hFFFF};
		end
	end

	// bias ramp: select 0 follows direction, select 1 forces the first acceleration time
	assign brate = (st_q.bramp_sel || st_q.btarget >= st_q.bias) ? st_q.accel : st_q.decel;
	// output ramp; only one time pair exists, so band crossing uses the first times too
	assign orate = (st_q.target >= st_q.outf) ? st_q.accel : st_q.decel;

	always_comb begin
		st_d = st_q;
		// register writes once address and data have both arrived
		if (s_axi_awvalid && st_q.awready) begin
			st_d.aw_have = 1'b1;
			st_d.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_q.wready) begin
			st_d.w_have = 1'b1;
			st_d.wdata  = s_axi_wdata;
		end
		st_d.limit_new = 1'b0;
		if (st_d.aw_have && st_d.w_have && !st_q.bvalid) begin
			st_d.aw_have = 1'b0;
			st_d.w_have  = 1'b0;
			st_d.bvalid  = 1'b1;
			st_d.bresp   = RESP_OKAY;
			if (st_d.awaddr < ADDR_JOG) begin
				st_d.preset[st_d.awaddr[5:2]] = st_d.wdata[FW-1:0];
			end else begin
				case (st_d.awaddr)
					ADDR_JOG:      st_d.jog = st_d.wdata[FW-1:0];
					ADDR_UPPER: begin
						st_d.upper_pct = (st_d.wdata[PW-1:0] > MAX_UPPER) ? MAX_UPPER : st_d.wdata[PW-1:0];
						st_d.limit_new = 1'b1;
					end
					ADDR_LOWER:    st_d.lower_pct = st_d.wdata[PW-1:0];
					ADDR_JUMP1:    st_d.jcentre[0] = st_d.wdata[FW-1:0];
					ADDR_JUMP2:    st_d.jcentre[1] = st_d.wdata[FW-1:0];
					ADDR_JWIDTH:   st_d.jwidth = st_d.wdata[FW-1:0];
					ADDR_HOLD:     st_d.hold_mode = (st_d.wdata[1:0] > HOLD_ACCEPT) ? HOLD_ACCEPT : st_d.wdata[1:0];
					ADDR_BSTEP:    st_d.bstep = (st_d.wdata[FW-1:0] > MAX_BSTEP) ? MAX_BSTEP : st_d.wdata[FW-1:0];
					ADDR_BRAMP:    st_d.bramp_sel = st_d.wdata[0];
					ADDR_SAVED:    st_d.saved = st_d.wdata[FW-1:0];
					ADDR_MAXF:     st_d.maxf = st_d.wdata[FW-1:0];
					ADDR_ACCEL:    st_d.accel = st_d.wdata[FW-1:0];
					ADDR_DECEL:    st_d.decel = st_d.wdata[FW-1:0];
					ADDR_FCODE_LO: st_d.fcode[3:0] = st_d.wdata;
					ADDR_FCODE_HI: st_d.fcode[7:4] = st_d.wdata;
					default:       st_d.bresp = RESP_SLVERR;
				endcase
			end
		end else if (st_q.bvalid && s_axi_bready) begin
			st_d.bvalid = 1'b0;
		end
		// reads answer one cycle after the address is taken
		if (st_q.rvalid && s_axi_rready) begin
			st_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_q.arready) begin
			st_d.rvalid = 1'b1;
			st_d.rresp  = RESP_OKAY;
			st_d.rdata  = 32'h0000_0000;
			if (s_axi_araddr < ADDR_JOG) begin
				st_d.rdata[FW-1:0] = st_q.preset[s_axi_araddr[5:2]];
			end else begin
				case (s_axi_araddr)
					ADDR_JOG:      st_d.rdata[FW-1:0] = st_q.jog;
					ADDR_UPPER:    st_d.rdata[PW-1:0] = st_q.upper_pct;
					ADDR_LOWER:    st_d.rdata[PW-1:0] = st_q.lower_pct;
					ADDR_JUMP1:    st_d.rdata[FW-1:0] = st_q.jcentre[0];
					ADDR_JUMP2:    st_d.rdata[FW-1:0] = st_q.jcentre[1];
					ADDR_JWIDTH:   st_d.rdata[FW-1:0] = st_q.jwidth;
					ADDR_HOLD:     st_d.rdata[1:0] = st_q.hold_mode;
					ADDR_BSTEP:    st_d.rdata[FW-1:0] = st_q.bstep;
					ADDR_BRAMP:    st_d.rdata[0] = st_q.bramp_sel;
					ADDR_SAVED:    st_d.rdata[FW-1:0] = st_q.saved;
					ADDR_MAXF:     st_d.rdata[FW-1:0] = st_q.maxf;
					ADDR_ACCEL:    st_d.rdata[FW-1:0] = st_q.accel;
					ADDR_DECEL:    st_d.rdata[FW-1:0] = st_q.decel;
					ADDR_FCODE_LO: st_d.rdata = st_q.fcode[3:0];
					ADDR_FCODE_HI: st_d.rdata = st_q.fcode[7:4];
					ADDR_STATUS:   st_d.rdata = {14'h0000, run, st_q.alarm, st_q.outf};
					default:       st_d.rresp = RESP_SLVERR;
				endcase
			end
		end
		st_d.awready = !st_d.aw_have && !st_d.bvalid;
		st_d.wready  = !st_d.w_have && !st_d.bvalid;
		st_d.arready = !st_d.rvalid;

		// a lowered upper limit pulls the presets down one cycle after the write
		if (st_q.limit_new) begin
			for (int p = 0; p < NUM_PRESET; p++) begin
				if (st_d.preset[p] > upper_hz) begin
					st_d.preset[p] = upper_hz;
				end
			end
		end

		// first up/down pair, stepping once per acceleration period
		st_d.utick = (st_q.utick >= st_q.accel) ? 16'h0000 : st_q.utick + 16'h0001;
		if (fn_act[FC_UP[3:0]] ^ fn_act[FC_DOWN[3:0]]) begin
			if (!run && mode == HOLD_SAVE) begin
				st_d.saved  = 16'h0000;
				st_d.ud_ref = 16'h0000;
			end else if ((run || mode == HOLD_ACCEPT) && st_q.utick >= st_q.accel) begin
				if (fn_act[FC_UP[3:0]] && st_q.ud_ref < upper_hz) begin
					st_d.ud_ref = st_q.ud_ref + 16'h0001;
				end else if (fn_act[FC_DOWN[3:0]] && st_q.ud_ref != 16'h0000) begin
					st_d.ud_ref = st_q.ud_ref - 16'h0001;
				end
			end
		end

		// second pair drives the bias
		st_d.press_prev = up2 ^ dn2;
		st_d.press_cnt  = (up2 ^ dn2) ? (long_press ? st_q.press_cnt : st_q.press_cnt + 32'd1) : 32'd0;
		st_d.btick      = (st_q.btick >= brate) ? 16'h0000 : st_q.btick + 16'h0001;
		if (up2 ^ dn2) begin
			if (st_q.bstep == 16'h0000 || long_press) begin
				// zero step: ramp freely at bias times; long press: follow first-pair times
				if ((long_press && st_q.utick >= st_q.accel) || (!long_press && st_q.btick >= brate)) begin
					if (up2 && st_q.bias < MAX_BSTEP) begin
						st_d.btarget = st_q.bias + 16'h0001;
					end else if (dn2 && st_q.bias != 16'h0000) begin
						st_d.btarget = st_q.bias - 16'h0001;
					end
				end
			end else if (!st_q.press_prev) begin
				st_d.btarget = up2 ? ((st_q.btarget + st_q.bstep > MAX_BSTEP) ? MAX_BSTEP : st_q.btarget + st_q.bstep)
				                   : ((st_q.btarget > st_q.bstep) ? st_q.btarget - st_q.bstep : 16'h0000);
			end
		end
		if (st_q.bias != st_d.btarget && (long_press || st_q.btick >= brate)) begin
			st_d.bias = (st_d.btarget > st_q.bias) ? st_q.bias + 16'h0001 : st_q.bias - 16'h0001;
		end

		// stop and restart handling of the up/down reference and bias
		st_d.run_prev = run;
		if (st_q.run_prev && !run) begin
			if (mode == HOLD_CLEAR) begin
				st_d.ud_ref  = 16'h0000;
				st_d.bias    = 16'h0000;
				st_d.btarget = 16'h0000;
			end else begin
				st_d.saved = st_q.ud_ref;
			end
		end else if (!st_q.run_prev && run && mode != HOLD_CLEAR) begin
			st_d.ud_ref = st_q.saved;
		end

		st_d.alarm = ud1_en && ud2_en;

		// pipeline the target, then ramp one count per rate period
		st_d.target = jumped[FW-1:0];
		st_d.tick   = (st_q.tick >= orate) ? 16'h0000 : st_q.tick + 16'h0001;
		if (st_q.tick >= orate && st_q.outf != st_q.target) begin
			st_d.outf = (st_q.target > st_q.outf) ? st_q.outf + 16'h0001 : st_q.outf - 16'h0001;
		end
	end

	// all state in one register; power loss acts as reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q           <= '0;
			st_q.preset    <= RST_PRESET;
			st_q.jog       <= RST_JOG;
			st_q.upper_pct <= RST_UPPER;
			st_q.lower_pct <= RST_LOWER;
			st_q.jwidth    <= RST_JWIDTH;
			st_q.maxf      <= RST_MAXF;
			st_q.accel     <= RST_RATE;
			st_q.decel     <= RST_RATE;
			st_q.fcode     <= {NUM_IN{RST_FCODE}};
			st_q.awready   <= 1'b1;
			st_q.wready    <= 1'b1;
			st_q.arready   <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign freq_reference  = st_q.outf;
	assign reference_alarm = st_q.alarm;
	assign s_axi_awready   = st_q.awready;
	assign s_axi_wready    = st_q.wready;
	assign s_axi_bresp     = st_q.bresp;
	assign s_axi_bvalid    = st_q.bvalid;
	assign s_axi_arready   = st_q.arready;
	assign s_axi_rdata     = st_q.rdata;
	assign s_axi_rresp     = st_q.rresp;
	assign s_axi_rvalid    = st_q.rvalid;
endmodule

// file: hw/input_sync.sv
// two-stage synchroniser for a vector of contact inputs
// assumes each bit is an independent level; no bus coherence is implied
`timescale 1ns/1ps
module input_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] raw,
	output logic      [WIDTH-1:0] synced
);
	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			synced <= '0;
		end else begin
			meta_q <= raw;
			synced <= meta_q;
		end
	end
endmodule

// file: verification/contact_model.sv
// contact and run-switch model standing at the terminal side of the selector
// assumes the bench asks for levels; contacts change just after a clock edge
`timescale 1ns/1ps
module contact_model (
	input  wire logic       aclk,
	input  wire logic [7:0] want_in,
	input  wire logic       run_want,
	output logic      [7:0] digital_in,
	output logic            run_cmd
);
	// contacts settle one cycle after the request, like a relay output stage
	always_ff @(posedge aclk) begin
		digital_in <= want_in;
		run_cmd    <= run_want;
	end
endmodule

// file: verification/fr_sel_asserts.sv
// port-level checks on the frequency reference selector
// assumes bind to the top module; one clock, synchronous active-low reset
`timescale 1ns/1ps
module fr_sel_asserts
	import freq_ref_pkg::*;
(
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire logic [FW-1:0] freq_reference,
	input wire logic          reference_alarm,
	input wire logic          s_axi_awvalid,
	input wire logic          s_axi_awready,
	input wire logic          s_axi_wvalid,
	input wire logic          s_axi_wready,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_bready,
	input wire logic [7:0]    s_axi_araddr,
	input wire logic          s_axi_arvalid,
	input wire logic          s_axi_arready,
	input wire logic [31:0]   s_axi_rdata,
	input wire logic [1:0]    s_axi_rresp,
	input wire logic          s_axi_rvalid,
	input wire logic          s_axi_rready
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// handshake steps
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_walk;
		s_axi_rvalid && !s_axi_arready ##1 !s_axi_rvalid && s_axi_arready;
	endsequence
	property p_reset_idle;
		disable iff (1'b0) !aresetn |=> freq_reference == 16'h0000 && s_axi_awready && !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	// guarded by past reset so a short reset pulse is not read as a jump
	property p_ramp_step;
		$past(aresetn) && freq_reference != $past(freq_reference) |->
			freq_reference == $past(freq_reference) + 16'h0001 || freq_reference == $past(freq_reference) - 16'h0001;
	endproperty
	property p_alarm_src;
		$past(aresetn) && $changed(reference_alarm) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
	endproperty
	property p_wr_answer;
		s_wr_take |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
	endproperty
	property p_b_release;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
	endproperty
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready ##1 s_axi_rready |-> s_rd_walk;
	endproperty
	property p_slverr_zero;
		s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h00000000;
	endproperty
	property p_status_alarm;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_STATUS |=> s_axi_rdata[STAT_ALARM] == $past(reference_alarm);
	endproperty
	a_reset_idle:   assert property (p_reset_idle) else $error("outputs not idle after reset");
	a_ramp_step:    assert property (p_ramp_step) else $error("reference moved more than one step");
	a_alarm_src:    assert property (p_alarm_src) else $error("alarm changed without a write");
	a_wr_answer:    assert property (p_wr_answer) else $error("write response late");
	a_b_release:    assert property (p_b_release) else $error("write channel not released");
	a_rd_answer:    assert property (p_rd_answer) else $error("read walk broken");
	a_slverr_zero:  assert property (p_slverr_zero) else $error("refused read returned data");
	a_status_alarm: assert property (p_status_alarm) else $error("status alarm bit differs from port");
endmodule

// file: verification/tb_frequency_reference_selector.sv
// self-checking bench for the frequency reference selector
// assumes a 125 MHz clock, AXI4-Lite master tasks and the contact model
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; $display("FAIL %0t got %h exp %h", $time, (a), (b)); end end
module tb_frequency_reference_selector
	import freq_ref_pkg::*;
;
	logic          aclk = 1'b0;
	logic          aresetn = 1'b0;
	logic          run_want = 1'b0;
	logic          run_cmd;
	logic [7:0]    want_in = 8'h00;
	logic [7:0]    digital_in;
	logic [FW-1:0] freq_reference;
	logic          reference_alarm;
	logic [7:0]    s_axi_awaddr = 8'h00;
	logic [7:0]    s_axi_araddr = 8'h00;
	logic          s_axi_awvalid = 1'b0;
	logic          s_axi_wvalid = 1'b0;
	logic          s_axi_arvalid = 1'b0;
	logic          s_axi_bready = 1'b1;
	logic          s_axi_rready = 1'b1;
	logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0]   s_axi_wdata = 32'h00000000;
	logic [31:0]   s_axi_rdata;
	logic [3:0]    s_axi_wstrb = 4'hF;
	logic [1:0]    s_axi_bresp, s_axi_rresp;
	int            num_errors = 0;
	int            total_checks = 0;
	logic [FW-1:0] p [16];
	logic [FW-1:0] jv;
	logic [FW-1:0] uh = 16'h1388;
	logic [FW-1:0] lh = 16'h0000;
	logic [FW-1:0] c1 = 16'h0000;
	logic [FW-1:0] c2 = 16'h0000;
	logic [FW-1:0] w = 16'h00C8;
	logic [31:0]   rd;
	logic [1:0]    rs;
	logic [3:0]    s;
	logic          j;

	frequency_reference_selector #(.LONG_PRESS_CYC(50)) u_dut (.*);
	contact_model u_contacts (.*);

	always #4 aclk = ~aclk;

	// write cycle; address and data offered together, bready held high
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		r = s_axi_bresp;
		if (n >= 50) num_errors++;
	endtask

	task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		d = s_axi_rdata;
		r = s_axi_rresp;
		if (n >= 50) num_errors++;
	endtask

	task automatic cfg(input logic [7:0] a, input logic [31:0] d);
		wr(a, d, rs);
		`CHK(rs, RESP_OKAY)
	endtask

	// expected reference: clamp first, then the two bands in order
	function automatic logic [FW-1:0] exp_ref(input logic [FW-1:0] v);
		logic [FW-1:0] x;
		x = (v > uh) ? uh : v;
		if (x < lh) x = lh;
		if (c1 != 0 && x >= c1 - w / 2 && x < c1 + w / 2) x = c1 + w / 2;
		if (c2 != 0 && x >= c2 - w / 2 && x < c2 + w / 2) x = c2 + w / 2;
		return x;
	endfunction

	// set contacts, let sync and target land, wait for the ramp, then watch it hold
	task automatic go(input logic [7:0] b, input logic [FW-1:0] e);
		int n;
		n = 0;
		want_in <= b;
		repeat (6) @(posedge aclk);
		while (freq_reference !== e && n < 6000) begin
			@(posedge aclk);
			n++;
		end
		repeat (20) @(posedge aclk);
		`CHK(freq_reference, e)
	endtask

	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// watchdog sized to the cycle budget of the whole run
	initial begin
		#800000;
		num_errors++;
		final_report();
	end

	initial begin
		void'($urandom(53620));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 16; i++) begin
			rdr(ADDR_PRESET0 + 8'(4 * i), rd, rs);
			`CHK(rd[15:0], RST_PRESET[i])
		end
		rdr(ADDR_UPPER, rd, rs);
		`CHK(rd[PW-1:0], RST_UPPER)
		rdr(ADDR_JWIDTH, rd, rs);
		`CHK(rd[15:0], RST_JWIDTH)
		rdr(8'h80, rd, rs);
		`CHK({rs, rd}, {RESP_SLVERR, 32'h00000000})
		wr(8'h80, 32'h00000001, rs);
		`CHK(rs, RESP_SLVERR)
		cfg(ADDR_ACCEL, 32'h00000000);
		cfg(ADDR_DECEL, 32'h00000000);
		cfg(ADDR_JWIDTH, 32'h000000C8);
		cfg(ADDR_FCODE_LO, {FC_STEP4, FC_STEP3, FC_STEP2, FC_STEP1});
		cfg(ADDR_FCODE_HI, {24'h000000, FC_JOG});
		run_want <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			p[i] = 16'($urandom_range(100, 4900));
			cfg(ADDR_PRESET0 + 8'(4 * i), {16'h0000, p[i]});
		end
		jv = 16'($urandom_range(100, 4900));
		cfg(ADDR_JOG, {16'h0000, jv});
		// random step patterns, jog now and then
		for (int k = 0; k < 10; k++) begin
			s = 4'($urandom_range(0, 15));
			j = ($urandom_range(0, 3) == 0);
			go({3'b000, j, s}, exp_ref(j ? jv : p[s]));
		end
		go(8'h0F, exp_ref(p[15]));
		go(8'h1F, exp_ref(jv));
		wr(ADDR_UPPER, 32'h000004B0, rs);
		rdr(ADDR_UPPER, rd, rs);
		`CHK(rd[PW-1:0], MAX_UPPER)
		p[15] = 16'h0FA0;
		cfg(ADDR_PRESET0 + 8'h3C, {16'h0000, p[15]});
		cfg(ADDR_UPPER, 32'h000001F4);
		uh = 16'h09C4;
		rdr(ADDR_PRESET0 + 8'h3C, rd, rs);
		`CHK(rd[15:0], uh)
		go(8'h0F, exp_ref(p[15]));
		cfg(ADDR_PRESET0, 32'h000003E8);
		cfg(ADDR_LOWER, 32'h0000012C);
		lh = 16'h05DC;
		go(8'h00, exp_ref(16'h03E8));
		c1 = 16'h0708;
		c2 = 16'h07D0;
		cfg(ADDR_JUMP1, {16'h0000, c1});
		cfg(ADDR_JUMP2, {16'h0000, c2});
		cfg(ADDR_PRESET0 + 8'h04, 32'h0000079E);
		cfg(ADDR_PRESET0 + 8'h08, 32'h000006D6);
		go(8'h02, exp_ref(16'h06D6));
		c2 = 16'h0000;
		cfg(ADDR_JUMP2, 32'h00000000);
		go(8'h01, exp_ref(16'h079E));
		go(8'h02, exp_ref(16'h06D6));
		`CHK(reference_alarm, 1'b0)
		cfg(ADDR_FCODE_HI, {16'h0000, FC_UP2, FC_UP});
		repeat (4) @(posedge aclk);
		`CHK(reference_alarm, 1'b1)
		rdr(ADDR_STATUS, rd, rs);
		`CHK(rd[STAT_ALARM], 1'b1)
		// first pair up while running climbs to the upper limit, stop clears it
		go(8'h12, exp_ref(uh));
		run_want <= 1'b0;
		go(8'h02, exp_ref(16'h0000));
		cfg(ADDR_HOLD, 32'h00000002);
		go(8'h12, exp_ref(uh));
		final_report();
	end
endmodule

bind frequency_reference_selector fr_sel_asserts u_chk (.*);
